// ### pmsf_host_model.sv
// Host-side link master model
`timescale 1ns/1ps
module pmsf_host_model
(
  output logic sck,
  output logic cs_n,
  output logic mosi,
  input  wire  miso
);
  initial
  begin
    sck  = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // Odd offset keeps the link clock edges off the pclk edges
  task automatic open_frame;
    #37 cs_n = 1'b0;
    #400;
  endtask
  // Filler on reads, never an acknowledgement
  task automatic xfer(input logic [15:0] d, output logic [15:0] q);
    for (int i = 15; i >= 0; i--)
    begin
      mosi = d[i];
      #400 sck = 1'b1;
      q[i] = miso;
      #400 sck = 1'b0;
    end
  endtask
  // Released data line shows no stale value
  task automatic close_frame;
    #400 cs_n = 1'b1;
    mosi = ~mosi;
    #600;
  endtask
endmodule

// ### pmsf_map.vh
// Address map, field positions and constants of the modem link framing block
`ifndef PMSF_MAP_VH
`define PMSF_MAP_VH

`define PMSF_ADDR_CTRL     8'h00
`define PMSF_ADDR_STATUS   8'h04
`define PMSF_ADDR_EVENTS   8'h08
`define PMSF_ADDR_EVINFO   8'h0c
`define PMSF_ADDR_FRAMES   8'h10
`define PMSF_ADDR_BOOTADR  8'h14
`define PMSF_ADDR_BUF_LO   8'h40
`define PMSF_ADDR_BUF_HI   8'h7c

`define PMSF_CTRL_FW_BIT   0
`define PMSF_CTRL_USER_BIT 1
`define PMSF_CTRL_CORE_BIT 2
`define PMSF_CTRL_WDG_BIT  3
`define PMSF_CTRL_RESET    4'h0

`define PMSF_BOOT_WORD_W   5'd8
`define PMSF_FW_WORD_W     5'd16
`define PMSF_BOOT_SIG      15'h2b5c
`define PMSF_FW_SIG_MEM    16'ha55a
`define PMSF_STATUS_REGION 16'h0000
`define PMSF_BUF_DEPTH     16
`define PMSF_BUF_AW        4
`define PMSF_IDX_MAX       8'hff
`define PMSF_IDX_ONE       8'h01
`define PMSF_IDX_TWO       8'h02
`define PMSF_IDX_THREE     8'h03
`define PMSF_IDX_FOUR      8'h04
`define PMSF_IDX_FIVE      8'h05

`endif

// ### pmsf_props.sv
// Assertion checker for the modem link framing top
`timescale 1ns/1ps
module pmsf_props
(
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        spi_sck,
  input wire        spi_cs_n,
  input wire        spi_mosi,
  input wire        spi_miso,
  input wire        spi_miso_oe,
  input wire        irq_n
);
  wire apw = psel & penable & pwrite;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  irq_set_a: assert property (apw && paddr == 8'h08 && |pwdata[15:0] |=> !irq_n)
    else $error("irq not raised");
  irq_clr_a: assert property (apw && paddr == 8'h08 && ~|pwdata[15:0] |=> irq_n)
    else $error("irq not cleared");
  irq_rst_a: assert property ($rose(presetn) |-> irq_n)
    else $error("irq set after reset");
  oe_on_a: assert property ($fell(spi_cs_n) |-> ##2 spi_miso_oe)
    else $error("miso not driven");
  oe_off_a: assert property ($rose(spi_cs_n) |-> ##2 !spi_miso_oe [*2])
    else $error("miso not released");
  miso_hold_a: assert property (spi_miso_oe && $changed(spi_miso) |-> !spi_sck)
    else $error("miso moved while clock high");
  no_wait_a: assert property (psel |-> pready)
    else $error("wait state seen");
  bad_addr_a: assert property (psel && penable && paddr inside {[8'h18:8'h3c]} |-> pslverr)
    else $error("unmapped access not refused");
  cover property ($fell(spi_cs_n));
  cover property ($fell(irq_n));
  cover property (psel && penable && pslverr);
endmodule

bind pmsf_top pmsf_props u_props
(
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
  .spi_miso_oe(spi_miso_oe), .irq_n(irq_n)
);

// ### pmsf_sync.v
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module pmsf_sync
#(
  parameter W = 1
)
(
  input  wire         clk,
  input  wire         rst_n,
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1)
    begin : g_bit
      reg s1_q;
      reg s2_q;
      always @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
        end
        else
        begin
          s1_q <= d[i];
          s2_q <= s1_q;
        end
      end
      assign q[i] = s2_q;
    end
  endgenerate
endmodule

// ### pmsf_top.v
// Modem link framing: link slave with boot and firmware layers, APB registers
//
// Summary of operation
// - Each frame is a host command answered by this modem as link slave.
// - Every command frame gets exactly one response, shifted out in that frame.
// - Frame length is free; chip select bounds each packet, never a fixed count.
// - Every accepted write packet is answered with its own response header.
// - Boot layer uses 8-bit words, firmware layer uses 16-bit words.
// - Two layers: boot for download and setup, firmware for messages.
// - Boot command opens with a four-byte physical address.
// - Boot response is 32 bits, top fifteen bits a fixed signature.
// - Boot response bits 16, 15, 14 flag user, core, watchdog reset.
// - Firmware command opens with a two-byte region identifier.
// - Length word top bit: zero is read, one is write.
// - Low fifteen length bits count 16-bit blocks.
// - Each firmware response opens with a fixed signature header word.
// - Signature is held byte-swapped and swapped back onto the link.
// - Payload layout depends on region identifier and the chosen stack.
// - Pending events drive the interrupt request line low.
// - Region zero is the status region: flags, timer, event lengths.
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "pmsf_map.vh"
module pmsf_top
#(
  parameter [14:0] BOOT_SIG   = `PMSF_BOOT_SIG,   // Arbitrary value
  parameter [15:0] FW_SIG_MEM = `PMSF_FW_SIG_MEM  // Arbitrary value, held swapped
)
(
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output reg         pslverr,
  input  wire        spi_sck,
  input  wire        spi_cs_n,
  input  wire        spi_mosi,
  output wire        spi_miso,
  output wire        spi_miso_oe,
  output wire        irq_n
);

  wire [2:0] pin_s;
  wire       sck_s;
  wire       cs_n_s;
  wire       mosi_s;

  // Chip select crosses inverted, so a synchroniser in reset reads as deselected
  // and no false frame start or frame count follows the release of reset
  pmsf_sync #(.W(3)) u_sync
  (
    .clk   (pclk),
    .rst_n (presetn),
    .d     ({spi_sck, ~spi_cs_n, spi_mosi}),
    .q     (pin_s)
  );
  assign sck_s  = pin_s[2];
  assign cs_n_s = ~pin_s[1];
  assign mosi_s = pin_s[0];

  reg  [3:0]  ctrl_q;
  reg  [15:0] events_q;
  reg  [31:0] evinfo_q;
  reg  [31:0] frames_q;
  reg  [31:0] boot_adr_q;
  reg  [31:0] timer_q;
  reg  [15:0] region_q;
  reg  [15:0] len_q;
  reg  [15:0] buf_q [0:`PMSF_BUF_DEPTH-1];
  reg         sck_d1_q;
  reg         cs_n_d1_q;
  reg  [15:0] rx_sh_q;
  reg  [15:0] tx_sh_q;
  reg  [4:0]  bit_cnt_q;
  reg  [7:0]  idx_q;
  reg         fw_frame_q;

  wire        fw_mode  = ctrl_q[`PMSF_CTRL_FW_BIT];
  wire        sck_rise = sck_s & ~sck_d1_q & ~cs_n_s;
  wire        sck_fall = ~sck_s & sck_d1_q & ~cs_n_s;
  wire        cs_start = ~cs_n_s & cs_n_d1_q;
  wire        cs_end   = cs_n_s & ~cs_n_d1_q;
  wire [4:0]  word_w   = fw_frame_q ? `PMSF_FW_WORD_W : `PMSF_BOOT_WORD_W;
  wire [15:0] rx_word  = {rx_sh_q[14:0], mosi_s};
  wire        word_end = sck_rise && (bit_cnt_q == word_w - 5'd1);
  wire        wr_cmd   = len_q[15];
  wire [14:0] blocks   = len_q[14:0];

  // Boot response word
  // Reset cause flags are set by software and only reported here
  wire [31:0] boot_resp = {BOOT_SIG,
                           ctrl_q[`PMSF_CTRL_USER_BIT],
                           ctrl_q[`PMSF_CTRL_CORE_BIT],
                           ctrl_q[`PMSF_CTRL_WDG_BIT],
                           14'h0000};

  reg  [15:0] tx_word;
  reg  [31:0] boot_sh;
  always @*
  begin
    tx_word = 16'h0000;
    boot_sh = 32'h0000_0000;
    // Layer latched at frame start, so a CTRL write mid-frame cannot split it
    if (!fw_frame_q)
    begin
      boot_sh = boot_resp << {idx_q[1:0], 3'b000};
      // Only the first four bytes carry the response
      tx_word = (idx_q < `PMSF_IDX_FOUR) ? {8'h00, boot_sh[31:24]} : 16'h0000;
    end
    else if (idx_q == 8'h00)
      tx_word = {FW_SIG_MEM[7:0], FW_SIG_MEM[15:8]};
    else if (wr_cmd)
      tx_word = 16'h0000;
    else if (region_q == `PMSF_STATUS_REGION)
    begin
      case (idx_q)
        `PMSF_IDX_ONE:   tx_word = events_q;
        `PMSF_IDX_TWO:   tx_word = timer_q[31:16];
        `PMSF_IDX_THREE: tx_word = timer_q[15:0];
        `PMSF_IDX_FOUR:  tx_word = evinfo_q[31:16];
        `PMSF_IDX_FIVE:  tx_word = evinfo_q[15:0];
        default:         tx_word = 16'h0000;
      endcase
    end
    else
      tx_word = buf_q[idx_q[`PMSF_BUF_AW-1:0] - 4'h1];
  end

  // Link engine: mode 0, sampled on rising and shifted on falling clock edge
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sck_d1_q   <= 1'b0;
      cs_n_d1_q  <= 1'b1;
      rx_sh_q    <= 16'h0000;
      tx_sh_q    <= 16'h0000;
      bit_cnt_q  <= 5'd0;
      idx_q      <= 8'h00;
      fw_frame_q <= 1'b0;
      region_q   <= 16'h0000;
      len_q      <= 16'h0000;
      boot_adr_q <= 32'h0000_0000;
      frames_q   <= 32'h0000_0000;
    end
    else
    begin
      sck_d1_q  <= sck_s;
      cs_n_d1_q <= cs_n_s;
      if (cs_start)
      begin
        fw_frame_q <= fw_mode;
        bit_cnt_q  <= 5'd0;
        idx_q      <= 8'h00;
        len_q      <= 16'h0000;
        tx_sh_q    <= fw_mode ? {FW_SIG_MEM[7:0], FW_SIG_MEM[15:8]}
                              : {boot_resp[31:24], 8'h00};
      end
      else if (cs_end)
        frames_q <= frames_q + 32'h0000_0001;
      else
      begin
        if (sck_rise)
        begin
          rx_sh_q   <= rx_word;
          bit_cnt_q <= word_end ? 5'd0 : bit_cnt_q + 5'd1;
        end
        if (word_end)
        begin
          // Index saturates so an overlong frame never wraps back to the header
          if (idx_q != `PMSF_IDX_MAX)
            idx_q <= idx_q + 8'h01;
          if (!fw_frame_q && idx_q < `PMSF_IDX_FOUR)
            boot_adr_q <= {boot_adr_q[23:0], rx_word[7:0]};
          if (fw_frame_q && idx_q == 8'h00)
            region_q <= rx_word;
          if (fw_frame_q && idx_q == `PMSF_IDX_ONE)
            len_q <= rx_word;
        end
        if (sck_fall)
        begin
          if (bit_cnt_q == 5'd0)
            tx_sh_q <= fw_frame_q ? tx_word : {tx_word[7:0], 8'h00};
          else
            tx_sh_q <= {tx_sh_q[14:0], 1'b0};
        end
      end
    end
  end

  // Boot bytes leave from the top lane too
  assign spi_miso    = tx_sh_q[15];
  assign spi_miso_oe = ~cs_n_s;

  // Payload words of a write land in the buffer, bounded by the block count
  // Region and length words come first, so payload ends two words past the count
  wire [15:0] wr_pos   = {8'h00, idx_q};
  wire [15:0] wr_limit = {1'b0, blocks} + {8'h00, `PMSF_IDX_TWO};
  wire spi_wr = word_end && fw_frame_q && wr_cmd && (idx_q >= `PMSF_IDX_TWO)
                && (wr_pos < wr_limit);
  wire [`PMSF_BUF_AW-1:0] spi_wr_idx = idx_q[`PMSF_BUF_AW-1:0] - 4'h2;

  wire apb_wr    = psel & penable & pwrite;
  wire apb_setup = psel & ~penable;
  wire buf_hit   = (paddr >= `PMSF_ADDR_BUF_LO) && (paddr <= `PMSF_ADDR_BUF_HI);
  wire [`PMSF_BUF_AW-1:0] apb_idx = paddr[5:2];

  // Link and APB writes to one entry in one cycle: the link wins
  genvar e;
  generate
    for (e = 0; e < `PMSF_BUF_DEPTH; e = e + 1)
    begin : g_buf
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          buf_q[e] <= 16'h0000;
        else if (spi_wr && spi_wr_idx == e)
          buf_q[e] <= rx_word;
        else if (apb_wr && buf_hit && apb_idx == e)
          buf_q[e] <= pwdata[15:0];
      end
    end
  endgenerate

  // Software registers and free-running timer reference
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q   <= `PMSF_CTRL_RESET;
      events_q <= 16'h0000;
      evinfo_q <= 32'h0000_0000;
      timer_q  <= 32'h0000_0000;
    end
    else
    begin
      timer_q <= timer_q + 32'h0000_0001;
      if (apb_wr)
      begin
        case (paddr)
          `PMSF_ADDR_CTRL:   ctrl_q   <= pwdata[3:0];
          `PMSF_ADDR_EVENTS: events_q <= pwdata[15:0];
          `PMSF_ADDR_EVINFO: evinfo_q <= pwdata;
          default:           ctrl_q   <= ctrl_q;
        endcase
      end
    end
  end

  // Level request: stays low until software clears every event bit
  assign irq_n = ~(|events_q);

  // Read data captured in the setup phase, so the access phase needs no wait
  reg [31:0] rd_mux;
  reg        rd_err;
  always @*
  begin
    rd_mux = 32'h0000_0000;
    rd_err = 1'b0;
    if (buf_hit)
      rd_mux = {16'h0000, buf_q[apb_idx]};
    else
    begin
      case (paddr)
        `PMSF_ADDR_CTRL:    rd_mux = {28'h0000000, ctrl_q};
        `PMSF_ADDR_STATUS:  rd_mux = {len_q, region_q};
        `PMSF_ADDR_EVENTS:  rd_mux = {16'h0000, events_q};
        `PMSF_ADDR_EVINFO:  rd_mux = evinfo_q;
        `PMSF_ADDR_FRAMES:  rd_mux = frames_q;
        `PMSF_ADDR_BOOTADR: rd_mux = boot_adr_q;
        default:            rd_err = 1'b1;
      endcase
    end
    if (paddr[1:0] != 2'b00)
      rd_err = 1'b1;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (apb_setup)
    begin
      prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr <= rd_err;
    end
  end

  // No wait states: read data is already captured in the setup cycle
  assign pready = 1'b1;

endmodule

// ### tb.sv
// Self-checking bench for the modem link framing top
`timescale 1ns/1ps
`include "pmsf_map.vh"
module tb;
  localparam logic [15:0] FW_MEM  = `PMSF_FW_SIG_MEM;
  localparam logic [15:0] FW_LINK = {FW_MEM[7:0], FW_MEM[15:8]};
  logic        pclk, presetn, psel, penable, pwrite, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, r;
  logic [15:0] w;
  wire  [31:0] prdata;
  wire         pready, pslverr, sck, cs_n, mosi, miso, oe, irq_n;
  int          mismatches, n_checks, cyc;
  pmsf_top uut
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .spi_sck(sck), .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso),
    .spi_miso_oe(oe), .irq_n(irq_n)
  );
  pmsf_host_model host (.sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso));
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_checks++;
    if (s !== x)
    begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic xf(input logic [15:0] d, input logic [15:0] x);
    host.xfer(d, w);
    chk({16'h0, w}, {16'h0, x});
  endtask
  task automatic t_regs;
    apb(1'b0, 8'h10, 32'h0);
    chk(r, 32'h0);
    apb(1'b0, 8'h00, 32'h0);
    chk(r, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, 8'h04, 32'hffff);
    chk({31'h0, e}, 32'h0);
  endtask
  task automatic t_boot;
    apb(1'b1, 8'h00, 32'he);
    host.open_frame;
    chk({31'h0, oe}, 32'h1);
    xf(16'h1234, {`PMSF_BOOT_SIG, 1'b1});
    xf(16'h5678, 16'hc000);
    host.close_frame;
    apb(1'b0, 8'h14, 32'h0);
    chk(r, 32'h12345678);
  endtask
  task automatic t_fw_wr;
    apb(1'b1, 8'h00, 32'h1);
    host.open_frame;
    xf(16'h0002, FW_LINK);
    xf(16'h8002, 16'h0);
    xf(16'hbeef, 16'h0);
    xf(16'h0123, 16'h0);
    xf(16'h7777, 16'h0);
    host.close_frame;
    apb(1'b0, 8'h44, 32'h0);
    chk(r, 32'h0123);
    apb(1'b0, 8'h48, 32'h0);
    chk(r, 32'h0);
  endtask
  task automatic t_fw_rd;
    host.open_frame;
    xf(16'h0002, FW_LINK);
    xf(16'h0002, 16'hbeef);
    xf(16'hffff, 16'h0123);
    host.close_frame;
  endtask
  task automatic t_status;
    apb(1'b1, 8'h0c, 32'habcd1234);
    apb(1'b1, 8'h08, 32'h5);
    @(negedge pclk);
    chk({31'h0, irq_n}, 32'h0);
    host.open_frame;
    xf(16'h0000, FW_LINK);
    xf(16'h0004, 16'h0005);
    host.xfer(16'hffff, w);
    host.xfer(16'hffff, w);
    xf(16'hffff, 16'habcd);
    xf(16'hffff, 16'h1234);
    host.close_frame;
    apb(1'b1, 8'h08, 32'h0);
    @(negedge pclk);
    chk({31'h0, irq_n}, 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    chk(r, 32'h4);
  endtask
  task automatic end_of_test;
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      end_of_test;
    end
  end
  initial
  begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h0;
    pwdata  = 32'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    t_regs;
    t_boot;
    t_fw_wr;
    t_fw_rd;
    t_status;
    end_of_test;
  end
endmodule
